// *** src/mmd_map_decoder.sv ***
// Memory map select decoder: page index register, target decode, read mux, port K selects
`timescale 1ns/1ps

module mmd_map_decoder #(
   parameter bit          WRITE_ANY_MODE = 1'b1,
   parameter logic [15:0] RAM_SIZE       = 16'h1000,
   parameter logic [15:0] EEP_SIZE       = 16'h0800,
   parameter logic [15:0] BDM_SIZE       = 16'h0100
) (
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   // Register port
   input  wire logic [9:0]  i_reg_addr,
   input  wire logic [7:0]  i_reg_wdata,
   input  wire logic        i_reg_wr,
   input  wire logic        i_reg_rd,
   output logic      [7:0]  o_reg_rdata,
   // Call and return page path
   input  wire logic        i_call_page_wr,
   input  wire logic [5:0]  i_call_page,
   output logic      [5:0]  o_page_index_bits,
   // Operating mode and integration switches
   input  wire logic        i_expanded_mode,
   input  wire logic        i_special_mode,
   input  wire logic        i_emulation_mode,
   input  wire logic        i_peripheral_mode,
   input  wire logic        i_port_e_emulation_enable,
   input  wire logic        i_port_k_emulation_enable,
   input  wire logic [1:0]  i_paging_partition_switches,
   input  wire logic        i_bdm_active,
   // Mapping bases
   input  wire logic [15:0] i_register_base_init,
   input  wire logic [15:0] i_ram_base,
   input  wire logic [15:0] i_eep_base,
   // CPU side
   input  wire logic        i_cpu_valid,
   input  wire logic        i_cpu_write,
   input  wire logic [15:0] i_cpu_addr,
   input  wire logic [15:0] i_cpu_wdata,
   input  wire logic        i_cpu_swap,
   output logic      [15:0] o_cpu_rdata,
   // Target read buses
   input  wire logic [15:0] i_bdm_rdata,
   input  wire logic [15:0] i_regs_rdata,
   input  wire logic [15:0] i_ram_rdata,
   input  wire logic [15:0] i_eep_rdata,
   input  wire logic [15:0] i_rom_rdata,
   input  wire logic [15:0] i_ext_rdata,
   // Selects and steered bus
   output logic             o_sel_bdm,
   output logic             o_sel_reg,
   output logic             o_sel_ram,
   output logic             o_sel_eep,
   output logic             o_sel_rom,
   output logic             o_sel_ext,
   output logic             o_bus_write,
   output logic      [15:0] o_bus_addr,
   output logic      [15:0] o_bus_wdata,
   // Port K pins
   input  wire logic [7:0]  i_pk_gpio_out,
   input  wire logic [7:0]  i_pk_gpio_oe,
   output logic      [7:0]  o_pk_out,
   output logic      [7:0]  o_pk_oe
);

   ////////////////////////////////////////////////////////////////////////////////
   // Functions

   // Window page is on chip when at or above the partition threshold
   function automatic logic page_internal(input logic [1:0] sw, input logic [5:0] pix);
      logic [5:0] lo;
      unique case (sw)
         2'b00: lo = mmd_pkg::PAGE_INT_SW0;
         2'b01: lo = mmd_pkg::PAGE_INT_SW1;
         2'b10: lo = mmd_pkg::PAGE_INT_SW2;
         2'b11: lo = mmd_pkg::PAGE_INT_SW3;
      endcase
      return pix >= lo;
   endfunction

   // Address falls within base .. base+size-1 (no wrap past 0xFFFF)
   function automatic logic in_range(input logic [15:0] a, input logic [15:0] base,
                                     input logic [15:0] size);
      logic [16:0] top;
      top = {1'b0, base} + {1'b0, size};
      return ({1'b0, a} >= {1'b0, base}) && ({1'b0, a} < top);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Page index register

   logic [5:0] page_reg;
   logic [5:0] page_next;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic       page_wr_ok;

   // R2 write gate
   assign page_wr_ok = WRITE_ANY_MODE || i_special_mode;

   // Dedicated call path beats a bus write in the same cycle; the winner lands next edge
   always_comb begin
      page_next  = page_reg;
      rdata_next = 8'h00;
      // R5 delayed bus write
      if (i_reg_wr && page_wr_ok && i_reg_addr == mmd_pkg::OFS_PROGRAM_PAGE_SELECT) begin
         // R20 upper bits dropped
         page_next = i_reg_wdata[5:0];
      end
      // R4 dedicated page path
      if (i_call_page_wr) begin
         page_next = i_call_page;
      end
      // R2 read anytime, R20 upper bits zero
      if (i_reg_rd && i_reg_addr == mmd_pkg::OFS_PROGRAM_PAGE_SELECT) begin
         rdata_next = {2'b00, page_reg};
      end
   end

   // R3 reset value follows write option
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         page_reg  <= WRITE_ANY_MODE ? mmd_pkg::PAGE_RESET_ANY_MODE
                                     : mmd_pkg::PAGE_RESET_SPECIAL_ONLY;
         rdata_reg <= 8'h00;
      end else begin
         page_reg  <= page_next;
         rdata_reg <= rdata_next;
      end
   end

   assign o_reg_rdata       = rdata_reg;
   assign o_page_index_bits = page_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Address decode

   mmd_pkg::mmd_sel_t sel_next;
   mmd_pkg::mmd_sel_t sel_reg;
   mmd_pkg::mmd_sel_t rd_sel_reg;
   logic [5:0]        sel_hot_next;
   logic [5:0]        sel_hot_reg;
   logic              in_window;
   logic              in_regs;
   logic              reg_removed;
   logic              reg_unimpl;
   logic [9:0]        reg_ofs;
   logic [15:0]       reg_ofs_full;
   logic              ecs_next;
   logic              xcs_next;
   logic [5:0]        xaddr_next;

   assign reg_ofs_full = i_cpu_addr - i_register_base_init;
   assign reg_ofs      = reg_ofs_full[9:0];
   // R1 program window
   assign in_window    = i_cpu_addr >= mmd_pkg::WINDOW_BASE && i_cpu_addr <= mmd_pkg::WINDOW_LAST;
   assign in_regs      = in_range(i_cpu_addr, i_register_base_init, mmd_pkg::REG_SPACE_SIZE);
   assign reg_unimpl   = reg_ofs > mmd_pkg::OFS_REG_IMPL_LAST;

   // Register locations handed to the external bus by mode
   always_comb begin
      reg_removed = 1'b0;
      // R10 ports A and B
      if (i_expanded_mode && reg_ofs <= mmd_pkg::OFS_PORT_B_DIR) begin
         reg_removed = 1'b1;
      end
      // R11 port E
      if (i_port_e_emulation_enable && (reg_ofs == mmd_pkg::OFS_PORT_E_DATA ||
                                        reg_ofs == mmd_pkg::OFS_PORT_E_DIR)) begin
         reg_removed = 1'b1;
      end
      // R12 peripheral mode block
      if (i_peripheral_mode && reg_ofs <= mmd_pkg::OFS_EXPANSION_LAST) begin
         reg_removed = 1'b1;
      end
      // R13 port K
      if (i_emulation_mode && i_port_k_emulation_enable &&
          (reg_ofs == mmd_pkg::OFS_PORT_K_DATA || reg_ofs == mmd_pkg::OFS_PORT_K_DIR)) begin
         reg_removed = 1'b1;
      end
   end

   // R9 priority chain, first hit wins so only one target results
   always_comb begin
      sel_next = mmd_pkg::SEL_NONE;
      if (i_cpu_valid) begin
         // R7 target decode
         if (i_bdm_active && in_range(i_cpu_addr, mmd_pkg::BDM_BASE, BDM_SIZE)) begin
            sel_next = mmd_pkg::SEL_BDM;
         end else if (in_regs && !reg_removed && !reg_unimpl) begin
            sel_next = mmd_pkg::SEL_REG;
         end else if (in_regs && reg_removed) begin
            // R10 removed registers become external
            sel_next = mmd_pkg::SEL_EXT;
         end else if (in_regs) begin
            sel_next = mmd_pkg::SEL_NONE;
         end else if (in_range(i_cpu_addr, i_ram_base, RAM_SIZE)) begin
            sel_next = mmd_pkg::SEL_RAM;
         end else if (in_range(i_cpu_addr, i_eep_base, EEP_SIZE)) begin
            sel_next = mmd_pkg::SEL_EEP;
         // R19 window partition
         end else if (in_window && page_internal(i_paging_partition_switches, page_reg)) begin
            sel_next = mmd_pkg::SEL_ROM;
         end else if (!in_window && i_cpu_addr >= mmd_pkg::ROM_UNPAGED_BASE) begin
            sel_next = mmd_pkg::SEL_ROM;
         end else if (i_expanded_mode) begin
            // R10 unclaimed space external
            sel_next = mmd_pkg::SEL_EXT;
         end
      end
   end

   // R8 one select per access, decoded ahead of the flops so each pin is a flop
   assign sel_hot_next = {sel_next == mmd_pkg::SEL_BDM, sel_next == mmd_pkg::SEL_REG,
                          sel_next == mmd_pkg::SEL_RAM, sel_next == mmd_pkg::SEL_EEP,
                          sel_next == mmd_pkg::SEL_ROM, sel_next == mmd_pkg::SEL_EXT};

   // Chip selects and extended address for port K
   always_comb begin
      // R14 emulation select on program memory
      ecs_next = i_port_k_emulation_enable && i_emulation_mode &&
                 sel_next == mmd_pkg::SEL_ROM;
      // R15 external select, R16 not for register space
      xcs_next = i_port_k_emulation_enable && !ecs_next && !in_regs &&
                 sel_next == mmd_pkg::SEL_EXT;
      // R18 extended address outputs
      if (in_window) begin
         xaddr_next = page_reg;
      end else if (i_cpu_addr < mmd_pkg::ROM_UNPAGED_BASE) begin
         xaddr_next = mmd_pkg::XADDR_QUAD0;
      end else if (i_cpu_addr < mmd_pkg::WINDOW_BASE) begin
         xaddr_next = mmd_pkg::XADDR_QUAD1;
      end else begin
         xaddr_next = mmd_pkg::XADDR_QUAD3;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Registered selects, steered bus and read mux

   logic [15:0] cpu_rdata_next;
   logic [15:0] rd_raw;
   logic        swap_reg;
   logic [7:0]  pk_out_next;
   logic [7:0]  pk_oe_next;
   logic        pk_emu_on;

   // R6 read mux uses the select of the previous access, data arrives one cycle later
   always_comb begin
      unique case (rd_sel_reg)
         mmd_pkg::SEL_BDM:  rd_raw = i_bdm_rdata;
         mmd_pkg::SEL_REG:  rd_raw = i_regs_rdata;
         mmd_pkg::SEL_RAM:  rd_raw = i_ram_rdata;
         mmd_pkg::SEL_EEP:  rd_raw = i_eep_rdata;
         mmd_pkg::SEL_ROM:  rd_raw = i_rom_rdata;
         mmd_pkg::SEL_EXT:  rd_raw = i_ext_rdata;
         mmd_pkg::SEL_NONE: rd_raw = 16'h0000;
         default:           rd_raw = 16'h0000;
      endcase
      // R6 byte swap
      cpu_rdata_next = swap_reg ? {rd_raw[7:0], rd_raw[15:8]} : rd_raw;
   end

   // Port K pins: selects only shown in expanded mode with emulation bit set
   always_comb begin
      pk_emu_on = i_port_k_emulation_enable && i_expanded_mode;
      if (pk_emu_on) begin
         pk_out_next = {~ecs_next, ~xcs_next, xaddr_next};
         pk_oe_next  = 8'hFF;
      end else begin
         // R17 general I/O when emulation bit clear
         pk_out_next = i_pk_gpio_out;
         pk_oe_next  = i_pk_gpio_oe;
      end
   end

   logic [15:0] cpu_rdata_reg;
   logic [15:0] bus_addr_reg;
   logic [15:0] bus_wdata_reg;
   logic        bus_write_reg;
   logic [7:0]  pk_out_reg;
   logic [7:0]  pk_oe_reg;

   // Selects idle high-impedance-free: pins start as inputs, selects inactive
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         sel_reg       <= mmd_pkg::SEL_NONE;
         sel_hot_reg   <= 6'h00;
         rd_sel_reg    <= mmd_pkg::SEL_NONE;
         swap_reg      <= 1'b0;
         cpu_rdata_reg <= 16'h0000;
         bus_addr_reg  <= 16'h0000;
         bus_wdata_reg <= 16'h0000;
         bus_write_reg <= 1'b0;
         pk_out_reg    <= 8'h00;
         pk_oe_reg     <= 8'h00;
      end else begin
         sel_reg       <= sel_next;
         sel_hot_reg   <= sel_hot_next;
         rd_sel_reg    <= sel_reg;
         swap_reg      <= i_cpu_swap;
         cpu_rdata_reg <= cpu_rdata_next;
         // R6 steer address and write data
         bus_addr_reg  <= i_cpu_addr;
         bus_wdata_reg <= i_cpu_wdata;
         bus_write_reg <= i_cpu_valid && i_cpu_write;
         pk_out_reg    <= pk_out_next;
         pk_oe_reg     <= pk_oe_next;
      end
   end

   // R8 one-hot selects, each straight from its own flop
   assign o_sel_bdm   = sel_hot_reg[5];
   assign o_sel_reg   = sel_hot_reg[4];
   assign o_sel_ram   = sel_hot_reg[3];
   assign o_sel_eep   = sel_hot_reg[2];
   assign o_sel_rom   = sel_hot_reg[1];
   assign o_sel_ext   = sel_hot_reg[0];
   assign o_cpu_rdata = cpu_rdata_reg;
   assign o_bus_addr  = bus_addr_reg;
   assign o_bus_wdata = bus_wdata_reg;
   assign o_bus_write = bus_write_reg;
   assign o_pk_out    = pk_out_reg;
   assign o_pk_oe     = pk_oe_reg;

endmodule // mmd_map_decoder

// *** src/mmd_pkg.sv ***
// Constants and types for the memory map select decoder
//
// Behaviour
// R1 - Six-bit page index picks one of 64 16K pages shown at 0x8000-0xBFFF.
// R2 - Page index always readable; writable in all modes or special modes only.
// R3 - Page index resets to 0x00 if always writable, else to 0x3C.
// R4 - Call and return instructions read and write page index via dedicated path.
// R5 - Bus write to page index takes effect one cycle later.
// R6 - Mux incoming read buses to CPU read bus, swap bytes, steer address/data out.
// R7 - Decode each address to core, register, memory or external target per mode.
// R8 - Never more than one select active in the same access.
// R9 - Priority: debug, registers, RAM, EEPROM, program memory, external.
// R10 - Expanded modes: unclaimed space external; port A and B registers go external.
// R11 - Port E emulation bit set: port E data and direction registers go external.
// R12 - Special peripheral mode: first sixteen expansion registers leave internal map.
// R13 - Emulation mode with port K emulation bit: port K registers go external.
// R14 - Port K bit 7 is active-low emulation select for program memory space.
// R15 - Port K bit 6 is active-low external select when emulation select inactive.
// R16 - External select stays inactive for unimplemented or removed register locations.
// R17 - Port K emulation bit clear: both select pins return to general I/O.
// R18 - Expanded with port K emulation: page bits drive extended address in window.
// R19 - Window access internal or external by page index and partition switches.
// R20 - Upper two page register bits read zero and ignore writes.
package mmd_pkg;

   // Register block offsets
   localparam logic [9:0]  OFS_PROGRAM_PAGE_SELECT = 10'h030;
   localparam logic [9:0]  OFS_PORT_A_DATA         = 10'h000;
   localparam logic [9:0]  OFS_PORT_B_DIR          = 10'h003;
   localparam logic [9:0]  OFS_PORT_E_DATA         = 10'h008;
   localparam logic [9:0]  OFS_PORT_E_DIR          = 10'h009;
   localparam logic [9:0]  OFS_EXPANSION_LAST      = 10'h00F;
   localparam logic [9:0]  OFS_PORT_K_DATA         = 10'h032;
   localparam logic [9:0]  OFS_PORT_K_DIR          = 10'h033;
   localparam logic [9:0]  OFS_REG_IMPL_LAST       = 10'h3FF;

   // Page index reset values
   localparam logic [5:0]  PAGE_RESET_ANY_MODE     = 6'h00;
   localparam logic [5:0]  PAGE_RESET_SPECIAL_ONLY = 6'h3C;

   // Address map figures
   localparam logic [15:0] WINDOW_BASE             = 16'h8000;
   localparam logic [15:0] WINDOW_LAST             = 16'hBFFF;
   localparam logic [15:0] ROM_UNPAGED_BASE        = 16'h4000;
   localparam logic [15:0] REG_SPACE_SIZE          = 16'h0400;
   localparam logic [15:0] BDM_BASE                = 16'hFF00;

   // Extended address constants outside the window, per 16K quadrant
   localparam logic [5:0]  XADDR_QUAD0             = 6'h3D;
   localparam logic [5:0]  XADDR_QUAD1             = 6'h3E;
   localparam logic [5:0]  XADDR_QUAD3             = 6'h3F;

   // Lowest internal page for each partition switch setting
   localparam logic [5:0]  PAGE_INT_SW0            = 6'h38;
   localparam logic [5:0]  PAGE_INT_SW1            = 6'h30;
   localparam logic [5:0]  PAGE_INT_SW2            = 6'h20;
   localparam logic [5:0]  PAGE_INT_SW3            = 6'h00;

   // Port K pin positions
   localparam int          PK_EMU_SEL_BIT          = 7;
   localparam int          PK_EXT_SEL_BIT          = 6;

   // Decoded target, SEL_NONE first, then targets highest priority first
   typedef enum logic [2:0] {
      SEL_NONE,
      SEL_BDM,
      SEL_REG,
      SEL_RAM,
      SEL_EEP,
      SEL_ROM,
      SEL_EXT
   } mmd_sel_t;

endpackage

// *** verif/mmd_monitor.sv ***
// Port checker for the memory map select decoder
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
module mmd_monitor #(
   parameter bit WRITE_ANY_MODE = 1'b1
) (
   // Clock and reset
   input wire logic       i_clk,
   input wire logic       i_rst,
   // Register port and page path
   input wire logic [9:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic       i_reg_wr,
   input wire logic       i_reg_rd,
   input wire logic [7:0] o_reg_rdata,
   input wire logic       i_call_page_wr,
   input wire logic [5:0] i_call_page,
   input wire logic [5:0] o_page_index_bits,
   // CPU access and selects
   input wire logic       i_cpu_valid,
   input wire logic       o_sel_bdm,
   input wire logic       o_sel_reg,
   input wire logic       o_sel_ram,
   input wire logic       o_sel_eep,
   input wire logic       o_sel_rom,
   input wire logic       o_sel_ext,
   // Port K
   input wire logic       i_port_k_emulation_enable,
   input wire logic [7:0] i_pk_gpio_out,
   input wire logic [7:0] o_pk_out
);
   // Helper terms; a call write in the same cycle overrides the bus
   wire [5:0] sel_vec = {o_sel_bdm, o_sel_reg, o_sel_ram, o_sel_eep, o_sel_rom, o_sel_ext};
   wire       pg_hit  = i_reg_addr == mmd_pkg::OFS_PROGRAM_PAGE_SELECT;
   wire       pg_wr   = i_reg_wr && pg_hit && !i_call_page_wr;
   wire       pg_rd   = i_reg_rd && pg_hit;
   wire [5:0] wr_page = i_reg_wdata[5:0];
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   chk_sel_onehot: assert property ($onehot0(sel_vec))
      else $error("more than one select high");
   chk_sel_cause: assert property (|sel_vec |-> $past(i_cpu_valid))
      else $error("select without access");
   chk_read_page: assert property ($past(pg_rd) && !$past(i_rst)
      |-> o_reg_rdata == {2'b00, $past(o_page_index_bits)}) else $error("page read wrong");
   chk_upper_zero: assert property (o_reg_rdata[7:6] == 2'b00)
      else $error("upper page bits not zero");
   chk_bus_write: assert property (WRITE_ANY_MODE && $past(pg_wr) && !$past(i_rst)
      |-> o_page_index_bits == $past(wr_page)) else $error("page write lost");
   chk_call_path: assert property ($past(i_call_page_wr) && !$past(i_rst)
      |-> o_page_index_bits == $past(i_call_page)) else $error("call page lost");
   chk_reset_page: assert property ($past(i_rst) |-> o_page_index_bits ==
      (WRITE_ANY_MODE ? mmd_pkg::PAGE_RESET_ANY_MODE : mmd_pkg::PAGE_RESET_SPECIAL_ONLY))
      else $error("page reset value wrong");
   // pins pass through when emulation is off
   chk_gpio_pass: assert property (!$past(i_port_k_emulation_enable) && !$past(i_rst)
      |-> o_pk_out == $past(i_pk_gpio_out)) else $error("port K not passed through");
endmodule // mmd_monitor

bind mmd_map_decoder mmd_monitor #(.WRITE_ANY_MODE(WRITE_ANY_MODE)) u_mon (
   .i_clk, .i_rst, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata,
   .i_call_page_wr, .i_call_page, .o_page_index_bits, .i_cpu_valid,
   .o_sel_bdm, .o_sel_reg, .o_sel_ram, .o_sel_eep, .o_sel_rom, .o_sel_ext,
   .i_port_k_emulation_enable, .i_pk_gpio_out, .o_pk_out
);

// *** verif/mmd_far_model.sv ***
// Far-side model: memories and peripherals answering the selects
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
module mmd_far_model (
   // Clock
   input  wire logic             i_clk,
   // Selects, debug space first, and steered address
   input  wire logic [5:0]       i_sel,
   input  wire logic [15:0]      i_addr,
   // Read buses, index matches select bit
   output logic      [5:0][15:0] o_rdata
);
   logic [15:0] churn_reg = 16'h5A3C;
   // selected target answers one cycle after its select, like a synchronous array
   // unselected buses change every cycle so a stale mux input never matches
   always_ff @(posedge i_clk) begin
      churn_reg <= churn_reg + 16'h1357;
      for (int k = 0; k < 6; k++) begin
         o_rdata[k] <= i_sel[k] ? {4'(6 - k), i_addr[11:0]} : churn_reg ^ 16'(k);
      end
   end
endmodule // mmd_far_model

// *** verif/tb.sv ***
// Self-checking bench for the memory map select decoder
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
module tb;
   typedef struct packed {
      logic [4:0]        mode; // Expanded, emulation, peripheral, port E, port K
      logic [1:0]        sw;
      logic [5:0]        page;
      logic [15:0]       addr;
      mmd_pkg::mmd_sel_t sel;
   } mmd_row_t;
   logic i_clk, i_rst, i_reg_wr, i_reg_rd, i_call_page_wr, i_cpu_valid, i_cpu_write, i_cpu_swap;
   logic [9:0]        i_reg_addr;
   logic [7:0]        i_reg_wdata, o_reg_rdata, i_pk_gpio_out, i_pk_gpio_oe, o_pk_out, o_pk_oe;
   logic [5:0]        i_call_page, o_page_index_bits, xa;
   logic [4:0]        mode;
   logic [1:0]        i_paging_partition_switches;
   logic [15:0]       i_cpu_addr, i_cpu_wdata, o_cpu_rdata, o_bus_addr, o_bus_wdata, f;
   logic [5:0][15:0]  fd;
   logic o_sel_bdm, o_sel_reg, o_sel_ram, o_sel_eep, o_sel_rom, o_sel_ext, o_bus_write, emulation_select_n, external_select_n;
   logic i_expanded_mode, i_emulation_mode, i_peripheral_mode;
   logic i_port_e_emulation_enable, i_port_k_emulation_enable;
   int                n_mismatch = 0;
   int                n_tests = 0;
   mmd_row_t          r;
   wire [5:0] sels = {o_sel_bdm, o_sel_reg, o_sel_ram, o_sel_eep, o_sel_rom, o_sel_ext};
   assign {i_expanded_mode, i_emulation_mode, i_peripheral_mode} = mode[4:2];
   assign {i_port_e_emulation_enable, i_port_k_emulation_enable} = mode[1:0];
   // Ordinary cases: RAM at 0x0000 under registers, EEPROM at 0x0C00 under RAM
   mmd_row_t rows [22] = '{
      '{5'h00, 2'd0, 6'h00, 16'h0100, mmd_pkg::SEL_REG},
      '{5'h10, 2'd0, 6'h00, 16'h0C00, mmd_pkg::SEL_RAM},
      '{5'h10, 2'd0, 6'h00, 16'h1000, mmd_pkg::SEL_EEP},
      '{5'h10, 2'd0, 6'h00, 16'h4000, mmd_pkg::SEL_ROM},
      '{5'h10, 2'd0, 6'h37, 16'h8000, mmd_pkg::SEL_EXT},
      '{5'h10, 2'd0, 6'h38, 16'h9000, mmd_pkg::SEL_ROM},
      '{5'h10, 2'd1, 6'h2F, 16'h8000, mmd_pkg::SEL_EXT},
      '{5'h10, 2'd2, 6'h20, 16'hA000, mmd_pkg::SEL_ROM},
      '{5'h10, 2'd3, 6'h00, 16'hBFFF, mmd_pkg::SEL_ROM},
      '{5'h00, 2'd0, 6'h00, 16'h2000, mmd_pkg::SEL_NONE},
      '{5'h10, 2'd0, 6'h00, 16'h2000, mmd_pkg::SEL_EXT},
      '{5'h10, 2'd0, 6'h00, 16'hFF10, mmd_pkg::SEL_BDM},
      '{5'h10, 2'd0, 6'h00, 16'h0000, mmd_pkg::SEL_EXT},
      '{5'h00, 2'd0, 6'h00, 16'h0003, mmd_pkg::SEL_REG},
      '{5'h12, 2'd0, 6'h00, 16'h0009, mmd_pkg::SEL_EXT},
      '{5'h10, 2'd0, 6'h00, 16'h0008, mmd_pkg::SEL_REG},
      '{5'h04, 2'd0, 6'h00, 16'h000F, mmd_pkg::SEL_EXT},
      '{5'h19, 2'd0, 6'h00, 16'h0032, mmd_pkg::SEL_EXT},
      '{5'h19, 2'd0, 6'h00, 16'h4000, mmd_pkg::SEL_ROM},
      '{5'h19, 2'd0, 6'h00, 16'h2000, mmd_pkg::SEL_EXT},
      '{5'h19, 2'd0, 6'h15, 16'hA000, mmd_pkg::SEL_EXT},
      '{5'h11, 2'd0, 6'h00, 16'h0032, mmd_pkg::SEL_REG}};
   // Debug space on and fixed bases are the only tied inputs
   mmd_map_decoder uut (.i_clk, .i_rst, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd,
      .o_reg_rdata, .i_call_page_wr, .i_call_page, .o_page_index_bits, .i_expanded_mode,
      .i_special_mode(mode[3] | mode[2]), .i_emulation_mode, .i_peripheral_mode,
      .i_port_e_emulation_enable, .i_port_k_emulation_enable, .i_paging_partition_switches,
      .i_bdm_active(1'b1), .i_register_base_init(16'h0000), .i_ram_base(16'h0000),
      .i_eep_base(16'h0C00), .i_cpu_valid, .i_cpu_write, .i_cpu_addr, .i_cpu_wdata, .i_cpu_swap,
      .o_cpu_rdata, .i_bdm_rdata(fd[5]), .i_regs_rdata(fd[4]), .i_ram_rdata(fd[3]),
      .i_eep_rdata(fd[2]), .i_rom_rdata(fd[1]), .i_ext_rdata(fd[0]), .o_sel_bdm, .o_sel_reg,
      .o_sel_ram, .o_sel_eep, .o_sel_rom, .o_sel_ext, .o_bus_write, .o_bus_addr, .o_bus_wdata,
      .i_pk_gpio_out, .i_pk_gpio_oe, .o_pk_out, .o_pk_oe);
   mmd_far_model far (.i_clk, .i_sel(sels), .i_addr(o_bus_addr), .o_rdata(fd));
   // Clock
   initial begin
      i_clk = 1'b0;
      forever #25 i_clk = ~i_clk;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic reg_wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge i_clk);
      {i_reg_wr, i_reg_addr, i_reg_wdata} <= {1'b1, a, d};
      @(posedge i_clk);
      i_reg_wr <= 1'b0;
   endtask
   task automatic reg_rd(input logic [9:0] a, input logic [7:0] exp);
      @(posedge i_clk);
      {i_reg_rd, i_reg_addr} <= {1'b1, a};
      @(posedge i_clk);
      i_reg_rd <= 1'b0;
      #1 chk(o_reg_rdata, exp, "register read");
   endtask
   task automatic give_verdict();
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // Watchdog, far beyond the roughly 170 cycles the tests need
   initial begin
      #(20000 * 50);
      n_mismatch++;
      give_verdict();
   end
   initial begin
      {i_rst, i_reg_wr, i_reg_rd, i_call_page_wr, i_cpu_valid, i_cpu_write, i_cpu_swap} = 7'h40;
      {i_reg_addr, i_reg_wdata, i_call_page, mode, i_paging_partition_switches} = '0;
      {i_cpu_addr, i_cpu_wdata, i_pk_gpio_out, i_pk_gpio_oe} = '0;
      repeat (3) @(posedge i_clk);
      i_rst <= 1'b0;
      reg_rd(mmd_pkg::OFS_PROGRAM_PAGE_SELECT, 8'h00);
      foreach (rows[i]) begin
         r = rows[i];
         @(posedge i_clk);
         {mode, i_paging_partition_switches} <= {r.mode, r.sw};
         reg_wr(mmd_pkg::OFS_PROGRAM_PAGE_SELECT, {2'b00, r.page});
         @(posedge i_clk);
         {i_cpu_valid, i_cpu_write, i_cpu_swap, i_cpu_addr} <= {1'b1, 1'(i), 1'(i), r.addr};
         {i_cpu_wdata, i_pk_gpio_out, i_pk_gpio_oe} <= {~r.addr, r.addr[7:0], r.addr[15:8]};
         @(posedge i_clk);
         i_cpu_valid <= 1'b0;
         #1 chk(sels, (r.sel == mmd_pkg::SEL_NONE) ? 0 : 16'h1 << (6 - r.sel), "sel");
         chk(o_bus_addr, r.addr, "bus addr");
         chk({15'h0000, o_bus_write}, {15'h0000, 1'(i)}, "bus write");
         chk(o_bus_wdata, ~r.addr, "bus data");
         emulation_select_n = !(r.sel == mmd_pkg::SEL_ROM && r.mode[3]);
         external_select_n = !(r.sel == mmd_pkg::SEL_EXT && r.addr > 16'h03FF && emulation_select_n);
         xa = (r.addr[15:14] == 2'd2) ? r.page : (r.addr[15:14] == 2'd0) ? 6'h3D :
              (r.addr[15:14] == 2'd1) ? 6'h3E : 6'h3F;
         if (!r.mode[0])
            chk({o_pk_out, o_pk_oe}, {r.addr[7:0], r.addr[15:8]}, "gpio pins");
         else if (r.mode[4])
            chk({o_pk_out, o_pk_oe}, {emulation_select_n, external_select_n, xa, 8'hFF}, "port K pins");
         f = (r.sel == mmd_pkg::SEL_NONE) ? 16'h0000 : {4'(r.sel), r.addr[11:0]};
         @(posedge i_clk);
         i_cpu_swap <= 1'b0;
         // Far side answers a cycle after the select, the mux flop adds one more
         @(posedge i_clk);
         #1 chk(o_cpu_rdata, i[0] ? {f[7:0], f[15:8]} : f, "cpu rdata");
         $display("row %0d done", i);
      end
      // Write then read back to back; upper bits dropped
      @(posedge i_clk);
      {i_reg_wr, i_reg_addr, i_reg_wdata} <= {1'b1, mmd_pkg::OFS_PROGRAM_PAGE_SELECT, 8'hFF};
      @(posedge i_clk);
      {i_reg_wr, i_reg_rd} <= 2'b01;
      @(posedge i_clk);
      i_reg_rd <= 1'b0;
      #1 chk(o_reg_rdata, 8'h3F, "back to back");
      // Call path and bus write in the same cycle
      @(posedge i_clk);
      {i_call_page_wr, i_call_page, i_reg_wr, i_reg_wdata} <= {1'b1, 6'h2A, 1'b1, 8'h11};
      @(posedge i_clk);
      {i_call_page_wr, i_reg_wr} <= 2'b00;
      #1 chk(o_page_index_bits, 6'h2A, "call path");
      $display("page path tests done");
      // Unmapped offset reads zero and does not disturb the page
      reg_wr(10'h031, 8'h07);
      reg_rd(10'h031, 8'h00);
      reg_rd(mmd_pkg::OFS_PROGRAM_PAGE_SELECT, 8'h2A);
      // Second reset in mid-run
      @(posedge i_clk);
      i_rst <= 1'b1;
      @(posedge i_clk);
      i_rst <= 1'b0;
      #1 chk(o_page_index_bits, mmd_pkg::PAGE_RESET_ANY_MODE, "reset page");
      $display("register and reset tests done");
      give_verdict();
   end
endmodule // tb
